// *** rtl/cfg_loader_defs.svh ***
// Constants of the configuration start-up and byte loader.
`ifndef CFG_LOADER_DEFS_SVH
`define CFG_LOADER_DEFS_SVH
`define SYS_CLK_NS 20
`define CFG_CLK_PERIOD_NS 1000
`define CFG_HALF_CYC (`CFG_CLK_PERIOD_NS / (2 * `SYS_CLK_NS))
`define MODE_MASTER_UP 3'h4
`define MODE_PERIPH 3'h5
`define MODE_MASTER_DOWN 3'h6
`define ADDR_UP_START 22'h000000
`define ADDR_DOWN_START 22'h03ffff
`define FILL_WINDOW 4'hf
`define PREAMBLE_CODE 4'h2
`define LEN_LAST_BIT 5'h17
`define SYNC_STAGE 3
`define STATUS_LOW_BITS 7'h7f
`define BUSY_MAX_PERIODS 9
`endif

// *** rtl/cfg_loader_pkg.sv ***
// Types shared by the configuration start-up and byte loader.
package cfg_loader_pkg;

  // Start-up clock source (bit 0) and done synchronisation (bit 1).
  typedef enum logic [1:0] {
    cfg_clocked_done_synced_start = 2'b00,
    user_clocked_done_synced_start = 2'b01,
    cfg_clocked_free_start = 2'b10,
    user_clocked_free_start = 2'b11
  } startup_mode_t;

  // Start-up options; each event picks one of the first four stages.
  typedef struct packed {
    startup_mode_t mode;
    logic [1:0] done_stage;
    logic [1:0] io_stage;
    logic [1:0] gsr_stage;
  } startup_opts_t;

  // Levels of every pin that comes from outside the clock domain.
  typedef struct packed {
    logic write_strobe_n;
    logic low_active_select;
    logic high_active_select;
    logic read_strobe_n;
    logic user_clk;
    logic done_pin;
    logic init_pin;
    logic [2:0] mode_select_pins;
    logic [7:0] data;
  } pin_bundle_t;

  // Bitstream header parser states.
  typedef enum logic [1:0] {
    HDR_FILL = 2'b00,
    HDR_LEN = 2'b01,
    HDR_BODY = 2'b10
  } hdr_state_t;

endpackage : cfg_loader_pkg

// *** rtl/pin_sync.sv ***
// Three-stage pin synchroniser that accepts a level once stages agree.
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1 // Number of pins.
) (
  input wire logic clk_in, // System clock.
  input wire logic arst_n_in, // Asynchronous reset, active low.
  input wire logic ce_in, // Clock enable; low freezes state.
  input wire logic [W-1:0] d_in, // Raw pin levels.
  output logic [W-1:0] q_out // Accepted pin levels.
);
  logic [W-1:0] s1; // First stage, read only by the second.
  logic [W-1:0] s2; // Second stage.
  logic [W-1:0] s3; // Third stage.
  logic [W-1:0] agree; // Bits where second and third stage agree.

  assign agree = ~(s2 ^ s3);

  // The accepted level follows a bit only when it has settled.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q_out <= '0;
    end else if (ce_in) begin
      s1 <= d_in;
      s2 <= s1;
      s3 <= s2;
      q_out <= (s2 & agree) | (q_out & ~agree);
    end
  end
endmodule : pin_sync

// *** rtl/byte_serializer.sv ***
// Double-buffered byte to serial converter with daisy-chain output.
`timescale 1ns/1ps
module byte_serializer (
  input wire logic clk_in, // System clock.
  input wire logic arst_n_in, // Asynchronous reset, active low.
  input wire logic ce_in, // Clock enable; low freezes state.
  input wire logic rise_in, // Config clock rising edge pulse.
  input wire logic fall_in, // Config clock falling edge pulse.
  input wire logic load_in, // Offer of a new byte.
  input wire logic [7:0] byte_in, // Byte offered.
  output logic hold_full_out, // Input buffer holds a byte.
  output logic [3:0] left_out, // Bits left in the shift register.
  output logic bit_out, // Bit shifted into the array.
  output logic bit_valid_out, // One-cycle pulse with each bit.
  output logic dout_out // Serial chain output.
);
  logic [7:0] hold; // Input buffer.
  logic [7:0] shreg; // Shift register, bit 0 goes first.
  logic move; // Buffer moves into the shift register.

  assign move = rise_in && hold_full_out && (left_out <= 4'h1);

  // The buffer fills on an offer and empties when it moves on.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hold <= 8'h00;
      hold_full_out <= 1'b0;
    end else if (ce_in) begin
      if (load_in && !hold_full_out) begin
        hold <= byte_in;
        hold_full_out <= 1'b1;
      end else if (move) begin
        hold_full_out <= 1'b0;
      end
    end
  end

  // Each rising edge consumes one bit; the last one makes room.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      shreg <= 8'h00;
      left_out <= 4'h0;
      bit_out <= 1'b0;
      bit_valid_out <= 1'b0;
    end else if (ce_in) begin
      bit_valid_out <= rise_in && (left_out != 4'h0);
      if (rise_in && (left_out != 4'h0)) begin
        bit_out <= shreg[0];
      end
      if (move) begin
        shreg <= hold;
        left_out <= 4'h8;
      end else if (rise_in && (left_out != 4'h0)) begin
        shreg <= {1'b0, shreg[7:1]};
        left_out <= left_out - 4'h1;
      end
    end
  end

  // The chain output changes only on falling edges, LSB first.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dout_out <= 1'b1;
    end else if (ce_in) begin
      if (fall_in && (left_out != 4'h0)) begin
        dout_out <= shreg[0];
      end
    end
  end
endmodule : byte_serializer

// *** rtl/config_startup_byte_loader.sv ***
// Configuration loader: start-up sequencer, EPROM and processor loading.
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "cfg_loader_defs.svh"

module config_startup_byte_loader (
  input wire logic sys_clk_in, // System clock, 50 MHz.
  input wire logic arst_n_in, // Asynchronous reset, active low.
  input wire logic ce_in, // Clock enable; low freezes all state.
  input wire logic [2:0] mode_select_pins_in, // Mode select pins.
  input wire logic init_in, // Clear-complete pin level.
  input wire logic done_in, // Wire-ANDed done pin level.
  input wire logic user_clk_in, // User start-up clock net.
  input wire logic write_strobe_n_in, // Write strobe, active low.
  input wire logic low_active_select_in, // Select, active low.
  input wire logic high_active_select_in, // Select, active high.
  input wire logic read_strobe_n_in, // Read strobe, active low.
  input wire logic [7:0] data_in, // Data bus input.
  input wire cfg_loader_pkg::startup_opts_t opts_in, // Start-up options.
  input wire logic mem_full_in, // Configuration memory is full.
  input wire logic frame_error_in, // Frame check error pulse.
  input wire logic wide_addr_in, // Bitstream asks for 22 lines.
  input wire logic low_voltage_in, // Low-voltage variant strap.
  output logic config_clock_out, // Configuration clock.
  output logic [21:0] addr_out, // EPROM address.
  output logic addr_oe_n_out, // Lower address enable, active low.
  output logic upper_addr_oe_n_out, // Upper lines enable, active low.
  output logic serial_chain_out, // Daisy-chain serial output.
  output logic cfg_bit_out, // Bit shifted into the array.
  output logic cfg_bit_valid_out, // Pulse with each array bit.
  output logic rdy_busy_out, // Ready high, busy low.
  output logic rdy_busy_oe_n_out, // Ready/busy enable, active low.
  output logic [7:0] data_out, // Status byte.
  output logic data_oe_n_out, // Data bus enable, active low.
  output logic done_out, // Done pin drive level.
  output logic done_oe_n_out, // Done pull-down enable, active low.
  output logic init_out, // Init pin drive level.
  output logic init_oe_n_out, // Init pull-down enable, active low.
  output logic io_active_out, // User I/O active.
  output logic gsr_active_out // Global set/reset still held.
);
  localparam logic [7:0] HALF = 8'(`CFG_HALF_CYC);
  localparam logic [8:0] BUSY_LIM =
    9'(`BUSY_MAX_PERIODS * 2 * `CFG_HALF_CYC);

  cfg_loader_pkg::pin_bundle_t pins_raw; // Pins before filtering.
  cfg_loader_pkg::pin_bundle_t pins; // Filtered pin levels.
  cfg_loader_pkg::hdr_state_t hdr_state; // Header parser state.
  logic [7:0] div_cnt; // Half-period counter.
  logic clk_run; // Configuration clock may toggle.
  logic tick; // Half period elapsed.
  logic rise_tick; // Configuration clock rises now.
  logic fall_tick; // Configuration clock falls now.
  logic init_up; // Clear-complete pin has risen.
  logic err; // Frame error seen.
  logic [2:0] mode; // Mode latched when init rises.
  logic master; // Either master parallel mode.
  logic periph; // Asynchronous peripheral mode.
  logic loading; // Data still being loaded.
  logic fetch; // EPROM byte captured now.
  logic wr_cond; // Peripheral write condition.
  logic wr_prev; // Write condition one cycle ago.
  logic wr_trail; // Trailing edge of a write.
  logic rd_cond; // Status read condition.
  logic [7:0] wr_data; // Byte seen during the write.
  logic hold_full; // Input buffer occupied.
  logic [3:0] left; // Bits left in the shift register.
  logic [3:0] win; // Last four header bits.
  logic [4:0] len_idx; // Length bit position.
  logic [23:0] length; // Loaded length count.
  logic [23:0] clk_count; // Clocks since init rose.
  logic start_cond; // Start-up may begin.
  logic [4:0] q; // Start-up shift register.
  logic [4:1] next_q; // Next value of the later stages.
  logic user_prev; // User clock one cycle ago.
  logic stage_tick; // Clock of the later stages.
  logic free; // Done pin not sampled.
  logic [8:0] busy_cnt; // Busy length, watched below.

  // Picks the stage that drives one start-up event.
  function automatic logic stage_pick(input logic [4:0] stages,
                                      input logic [1:0] sel);
    stage_pick = stages[sel];
  endfunction : stage_pick

  assign pins_raw = '{write_strobe_n: write_strobe_n_in,
                      low_active_select: low_active_select_in,
                      high_active_select: high_active_select_in,
                      read_strobe_n: read_strobe_n_in,
                      user_clk: user_clk_in,
                      done_pin: done_in,
                      init_pin: init_in,
                      mode_select_pins: mode_select_pins_in,
                      data: data_in};

  // All outside pins pass the three-stage filter.
  pin_sync #(.W($bits(cfg_loader_pkg::pin_bundle_t))) u_sync (
    .clk_in(sys_clk_in),
    .arst_n_in(arst_n_in),
    .ce_in(ce_in),
    .d_in(pins_raw),
    .q_out(pins)
  );

  // In peripheral mode the clock parks high once start-up ends.
  assign clk_run = init_up && !(periph && q[4] && config_clock_out);
  assign tick = clk_run && (div_cnt == HALF - 8'h01);
  assign rise_tick = tick && !config_clock_out;
  assign fall_tick = tick && config_clock_out;

  // The divider makes the configuration clock from the system clock.
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      div_cnt <= 8'h00;
      config_clock_out <= 1'b0;
    end else if (ce_in) begin
      if (!clk_run || tick) begin
        div_cnt <= 8'h00;
      end else begin
        div_cnt <= div_cnt + 8'h01;
      end
      if (tick) begin
        config_clock_out <= !config_clock_out;
      end
    end
  end

  assign master = (mode == `MODE_MASTER_UP) || (mode == `MODE_MASTER_DOWN);
  assign periph = (mode == `MODE_PERIPH);
  assign err = !init_oe_n_out;
  assign loading = init_up && !err && !q[0];
  assign init_out = 1'b0;
  assign done_out = 1'b0;

  // Mode pins are followed until the clear-complete pin rises.
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      init_up <= 1'b0;
      mode <= 3'h0;
    end else if (ce_in) begin
      if (!init_up) begin
        mode <= pins.mode_select_pins;
        init_up <= pins.init_pin;
      end
    end
  end

  // A frame error stops loading and pulls init low for good.
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      init_oe_n_out <= 1'b1;
    end else if (ce_in) begin
      if (frame_error_in) begin
        init_oe_n_out <= 1'b0;
      end
    end
  end

  // Master capture happens the rise before the buffer moves on.
  assign fetch = master && loading && rise_tick && !hold_full &&
                 (left <= 4'h2);

  // The EPROM address starts at the mode's end and steps per byte.
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      addr_out <= `ADDR_UP_START;
    end else if (ce_in) begin
      if (!init_up) begin
        if (pins.mode_select_pins == `MODE_MASTER_DOWN) begin
          addr_out <= `ADDR_DOWN_START;
        end else begin
          addr_out <= `ADDR_UP_START;
        end
      end else if (fetch && mode == `MODE_MASTER_DOWN) begin
        addr_out <= addr_out - 22'h000001;
      end else if (fetch) begin
        addr_out <= addr_out + 22'h000001;
      end
    end
  end

  // Address enables; upper lines follow the width or the variant.
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      addr_oe_n_out <= 1'b1;
      upper_addr_oe_n_out <= 1'b1;
    end else if (ce_in) begin
      addr_oe_n_out <= !(master && init_up);
      upper_addr_oe_n_out <= !(master && init_up &&
                               (wide_addr_in || low_voltage_in));
    end
  end

  assign wr_cond = !pins.write_strobe_n && !pins.low_active_select &&
                   pins.read_strobe_n && pins.high_active_select;
  assign rd_cond = periph && pins.write_strobe_n &&
                   !pins.low_active_select && pins.high_active_select &&
                   !pins.read_strobe_n;
  assign wr_trail = periph && loading && wr_prev && !wr_cond;

  // The byte is held while the write lasts and taken as it ends.
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_prev <= 1'b0;
      wr_data <= 8'h00;
    end else if (ce_in) begin
      wr_prev <= wr_cond;
      if (wr_cond) begin
        wr_data <= pins.data;
      end
    end
  end

  // Buffer and shifter feed the array and the daisy chain.
  byte_serializer u_ser (
    .clk_in(sys_clk_in),
    .arst_n_in(arst_n_in),
    .ce_in(ce_in),
    .rise_in(rise_tick),
    .fall_in(fall_tick),
    .load_in((fetch || wr_trail) && !err),
    .byte_in(fetch ? pins.data : wr_data),
    .hold_full_out(hold_full),
    .left_out(left),
    .bit_out(cfg_bit_out),
    .bit_valid_out(cfg_bit_valid_out),
    .dout_out(serial_chain_out)
  );

  // Handshake undriven before init rises; status byte driven on any peripheral-mode read.
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdy_busy_out <= 1'b1;
      rdy_busy_oe_n_out <= 1'b1;
      data_out <= 8'hff;
      data_oe_n_out <= 1'b1;
    end else if (ce_in) begin
      rdy_busy_out <= !hold_full;
      rdy_busy_oe_n_out <= !(periph && init_up);
      data_out <= {!hold_full, `STATUS_LOW_BITS};
      data_oe_n_out <= !rd_cond;
    end
  end

  // Header parser: fill ones, preamble, then the 24-bit length.
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hdr_state <= cfg_loader_pkg::HDR_FILL;
      win <= `FILL_WINDOW;
      len_idx <= 5'h00;
      length <= 24'h000000;
    end else if (ce_in && cfg_bit_valid_out && !err) begin
      case (hdr_state)
        cfg_loader_pkg::HDR_FILL: begin
          win <= {win[2:0], cfg_bit_out};
          if ({win[2:0], cfg_bit_out} == `PREAMBLE_CODE) begin
            hdr_state <= cfg_loader_pkg::HDR_LEN;
          end
        end
        cfg_loader_pkg::HDR_LEN: begin
          length <= {length[22:0], cfg_bit_out};
          len_idx <= len_idx + 5'h01;
          if (len_idx == `LEN_LAST_BIT) begin
            hdr_state <= cfg_loader_pkg::HDR_BODY;
          end
        end
        default: begin
          hdr_state <= cfg_loader_pkg::HDR_BODY;
        end
      endcase
    end
  end

  // Configuration clocks are counted from the rise of init.
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      clk_count <= 24'h000000;
    end else if (ce_in) begin
      if (rise_tick) begin
        clk_count <= clk_count + 24'h000001;
      end
    end
  end

  assign start_cond = mem_full_in && !err && (clk_count == length) &&
                      (hdr_state == cfg_loader_pkg::HDR_BODY);
  assign free = opts_in.mode[1];
  assign stage_tick = opts_in.mode[0] ?
                      (pins.user_clk && !user_prev) : rise_tick;

  // Later stages shift; the fourth may wait for the done level.
  for (genvar i = 1; i <= 4; i++) begin : g_stage
    if (i == `SYNC_STAGE) begin : g_sync
      assign next_q[i] = q[i-1] && (free || pins.done_pin);
    end else begin : g_plain
      assign next_q[i] = q[i-1];
    end
  end

  // The start-up shift register.
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      q <= 5'h00;
      user_prev <= 1'b0;
    end else if (ce_in) begin
      user_prev <= pins.user_clk;
      if (rise_tick && start_cond) begin
        q[0] <= 1'b1;
      end
      if (stage_tick && q[0]) begin
        q[4:1] <= next_q;
      end
    end
  end

  // Each event follows its own chosen stage among the first four.
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      done_oe_n_out <= 1'b0;
      io_active_out <= 1'b0;
      gsr_active_out <= 1'b1;
    end else if (ce_in) begin
      done_oe_n_out <= stage_pick(q, opts_in.done_stage);
      io_active_out <= stage_pick(q, opts_in.io_stage);
      gsr_active_out <= !stage_pick(q, opts_in.gsr_stage);
    end
  end

  // Length of the current busy interval, read only by a check.
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      busy_cnt <= 9'h000;
    end else if (ce_in) begin
      busy_cnt <= hold_full ? busy_cnt + 9'h001 : 9'h000;
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in || !ce_in);

  AST_START_CAUSE:
    assert property ($rose(q[0]) |-> $past(start_cond && rise_tick))
    else $error("Start-up began without a length match.");
  AST_FIRST_STAGE:
    assert property (start_cond && rise_tick |=> q[0])
    else $error("First stage missed the start edge.");
  AST_DONE_RELEASE:
    assert property (stage_pick(q, opts_in.done_stage) |=> done_oe_n_out)
    else $error("Done not released by its stage.");
  AST_DONE_STALL:
    assert property (!free && !pins.done_pin && !q[3] |=> !q[3])
    else $error("Fourth stage advanced while done held low.");
  AST_FREE_ADVANCE:
    assert property (free && q[2] && !q[3] && stage_tick |=> q[3])
    else $error("Free start-up failed to advance.");
  AST_STAGE_CLOCK:
    assert property (!stage_tick |=> $stable(q[4:1]))
    else $error("Later stages moved without their clock.");
  AST_ADDR_UP:
    assert property (fetch && mode == `MODE_MASTER_UP
                     |=> addr_out == $past(addr_out) + 22'h000001)
    else $error("Up mode address did not increment.");
  AST_ADDR_DOWN:
    assert property (fetch && mode == `MODE_MASTER_DOWN
                     |=> addr_out == $past(addr_out) - 22'h000001)
    else $error("Down mode address did not decrement.");
  AST_UPPER_LINES:
    assert property (!wide_addr_in && !low_voltage_in |=> upper_addr_oe_n_out)
    else $error("Upper address lines driven without wide mode.");
  AST_CHAIN_FALL:
    assert property ($changed(serial_chain_out) |-> $past(fall_tick))
    else $error("Chain output changed off a falling edge.");
  AST_WRITE_BUSY:
    assert property (wr_trail && !hold_full && !err |=> ##1 !rdy_busy_out)
    else $error("Write did not raise busy.");
  AST_BUSY_BOUND:
    assert property (busy_cnt <= BUSY_LIM)
    else $error("Busy lasted over nine clock periods.");
  AST_STATUS:
    assert property (rd_cond |=> !data_oe_n_out &&
                     data_out == {!$past(hold_full), `STATUS_LOW_BITS})
    else $error("Status byte wrong during a read.");
  AST_ERROR_INIT:
    assert property (frame_error_in |=> !init_oe_n_out)
    else $error("Frame error did not pull init low.");

  COV_STARTUP_DONE: cover property ($rose(q[4]));
  COV_BUSY_READY: cover property ($fell(rdy_busy_out) ##[1:500] rdy_busy_out);
  COV_STATUS_READ: cover property (rd_cond);
  COV_FRAME_ERROR: cover property ($fell(init_oe_n_out));
endmodule : config_startup_byte_loader

// *** sim/eprom_model.sv ***
// Byte-wide EPROM seen by the loader in master modes.
`timescale 1ns/1ps
module eprom_model (
  input wire logic [21:0] addr_in, // Address from the loader.
  input wire logic oe_n_in, // Address enable, active low.
  output logic [7:0] data_out // Byte stored at the address.
);
  // Byte follows address; undriven address gives the inverted low address byte.
  always_comb begin
    data_out = oe_n_in ? ~addr_in[7:0] : addr_in[7:0] ^ 8'h5a;
  end
endmodule : eprom_model

// *** sim/config_startup_byte_loader_tb.sv ***
// Self-checking bench of the configuration loader.
`timescale 1ns/1ps
module config_startup_byte_loader_tb;
  typedef struct packed {
    logic [2:0] m; logic lv; logic [21:0] a0; logic [21:0] a1; logic u;
  } row_t;
  logic sys_clk_in, arst_n_in, init, ws_n, cs0_n, cs1, rs_n, ferr, lv;
  logic [2:0] mode;
  logic [7:0] hb, rom_q, dq;
  logic [21:0] addr;
  logic config_clock, a_oe_n, u_oe_n, sdo, rb, rb_oe_n, d_oe_n, dn_oe_n, i_oe_n;
  logic io_act, gsr_act;
  int error_cnt = 0, n_tests = 0, i, r;
  // Mode, strap, first and second address, upper enable.
  row_t rows [3] = '{{3'h4, 1'b0, 22'h0, 22'h1, 1'b1},
    {3'h6, 1'b1, 22'h3ffff, 22'h3fffe, 1'b0},
    {3'h4, 1'b1, 22'h0, 22'h1, 1'b0}};
  eprom_model rom (.addr_in(addr), .oe_n_in(a_oe_n), .data_out(rom_q));
  config_startup_byte_loader dut (.sys_clk_in(sys_clk_in),
    .arst_n_in(arst_n_in), .ce_in(1'b1), .mode_select_pins_in(mode),
    .init_in(init & i_oe_n), .done_in(dn_oe_n), .user_clk_in(1'b0),
    .write_strobe_n_in(ws_n), .low_active_select_in(cs0_n),
    .high_active_select_in(cs1), .read_strobe_n_in(rs_n),
    .data_in(mode[0] ? hb : rom_q),
    .opts_in(cfg_loader_pkg::startup_opts_t'(8'h1b)), .mem_full_in(1'b0),
    .frame_error_in(ferr), .wide_addr_in(1'b0), .low_voltage_in(lv),
    .config_clock_out(config_clock), .addr_out(addr), .addr_oe_n_out(a_oe_n),
    .upper_addr_oe_n_out(u_oe_n), .serial_chain_out(sdo),
    .cfg_bit_out(), .cfg_bit_valid_out(), .rdy_busy_out(rb),
    .rdy_busy_oe_n_out(rb_oe_n), .data_out(dq), .data_oe_n_out(d_oe_n),
    .done_out(), .done_oe_n_out(dn_oe_n), .init_out(),
    .init_oe_n_out(i_oe_n), .io_active_out(io_act),
    .gsr_active_out(gsr_act));
  // Free-running system clock.
  initial begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end
  // Compares one value and counts it.
  task check(input logic [23:0] s, input logic [23:0] e);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : check
  // Prints the verdict and stops.
  task test_done;
    if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  // Resets the loader in one mode, then raises the clear pin.
  task do_reset(input logic [2:0] m, input logic l);
    {arst_n_in, init, ferr, rs_n, cs0_n, cs1, ws_n} <= 7'h0f;
    hb <= 8'hff;
    mode <= m;
    lv <= l;
    repeat (8) @(posedge sys_clk_in);
    check({dn_oe_n, sdo, gsr_act, io_act, rb}, 5'h0d);
    arst_n_in <= 1'b1;
    repeat (5) @(posedge sys_clk_in);
    init <= 1'b1;
  endtask : do_reset
  // The run cannot need this long.
  initial begin
    #400us;
    error_cnt++;
    test_done;
  end
  initial begin
    for (r = 0; r < 3; r++) begin
      do_reset(rows[r].m, rows[r].lv);
      for (i = 0; i < 300 && a_oe_n !== 1'b0; i++) @(posedge sys_clk_in);
      #1 check(addr, rows[r].a0);
      check(u_oe_n, rows[r].u);
      for (i = 0; i < 1200 && addr === rows[r].a0; i++) @(posedge sys_clk_in);
      #1 check(addr, rows[r].a1);
    end
    do_reset(3'h5, 1'b0);
    for (i = 0; i < 300 && rb_oe_n !== 1'b0; i++) @(posedge sys_clk_in);
    check(rb, 1'b1);
    @(posedge sys_clk_in);
    {ws_n, cs0_n} <= 2'b00;
    // The byte is taken as the write ends, so the write must end first.
    repeat (6) @(posedge sys_clk_in);
    ws_n <= 1'b1;
    for (i = 0; i < 200 && rb !== 1'b0; i++) @(posedge sys_clk_in);
    #1 check(rb, 1'b0);
    for (i = 0; i < 300 && rb !== 1'b1; i++) @(posedge sys_clk_in);
    check(i > 0 && i <= 100, 1'b1);
    repeat (50) @(posedge sys_clk_in);
    {ws_n, rs_n} <= 2'b10;
    repeat (6) @(posedge sys_clk_in);
    #1 check({d_oe_n, dq}, 9'h0ff);
    rs_n <= 1'b1;
    ferr <= 1'b1;
    @(posedge sys_clk_in);
    ferr <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
    check(i_oe_n, 1'b0);
    test_done;
  end
endmodule : config_startup_byte_loader_tb
